// ===== src/bwdt_core.sv
`timescale 1ns/100ps
// What this block does and what its host must do
// R1: On expiry, pulse either a cold reset or an NMI toward the processor.
// R2: A non-zero load starts the countdown; reaching zero fires expiry.
// R3: A zero load disables the watchdog; nothing fires.
// R4: Host reloads before zero; each reload restarts from the new value.
// R5: Count unit is seconds or minutes, set by a configuration input.
// R6: Host keeps ten percent margin between refresh and time-out.
// R7: Host loads zero before its program ends, else reset follows.
// R8: Host sets the period through firmware service 6FH, sub-function 2.
// R9: Eight-bit binary counter, decremented once per selected timebase tick.
module bwdt_core #(
   parameter int SEC_CYCLES = bwdt_pkg::SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire bwdt_pkg::bwdt_load_t loadReq,
   input wire logic unitMinutes,
   input wire logic actionNmi,
   output logic sysResetReq,
   output logic nmiReq,
   output logic running,
   output logic [bwdt_pkg::COUNT_W-1:0] countOut
);
   bwdt_pkg::bwdt_state_t stateQ, stateD;
   logic [bwdt_pkg::COUNT_W-1:0] countQ, countD;
   logic [bwdt_pkg::PULSE_W-1:0] pulseQ, pulseD;
   logic unitQ;
   logic actionQ;
   logic tick;

   wire loadNonZero = loadReq.load &&
      (loadReq.value != bwdt_pkg::COUNT_ZERO);
   wire loadZero = loadReq.load &&
      (loadReq.value == bwdt_pkg::COUNT_ZERO);
   wire lastTick = tick && (countQ == 8'h01);
   wire pulseDone = (pulseQ ==
      bwdt_pkg::PULSE_W'(bwdt_pkg::PULSE_CYCLES - 1));

   // Unit is latched per load so a mid-count change cannot mix units
   bwdt_timebase #(.SEC_CYCLES(SEC_CYCLES)) u_timebase (
      .clk(clk),
      .rst(rst),
      .clear(loadReq.load),
      .unitMinutes(unitQ),
      .tick(tick)
   );

   always_comb begin
      stateD = stateQ;
      countD = countQ;
      pulseD = pulseQ;
      case (stateQ)
         bwdt_pkg::BWDT_IDLE: begin
            if (loadNonZero) begin
               stateD = bwdt_pkg::BWDT_COUNT; // R2
               countD = loadReq.value;
            end
         end
         bwdt_pkg::BWDT_COUNT: begin
            if (loadZero) begin
               stateD = bwdt_pkg::BWDT_IDLE; // R3
               countD = bwdt_pkg::COUNT_ZERO;
            end else if (loadNonZero) begin
               countD = loadReq.value; // R4
            end else if (lastTick) begin
               stateD = bwdt_pkg::BWDT_FIRE; // R2
               countD = bwdt_pkg::COUNT_ZERO;
               pulseD = '0;
            end else if (tick) begin
               countD = countQ - 8'h01; // R9
            end
         end
         bwdt_pkg::BWDT_FIRE: begin
            // Pulse runs to completion; loads during it only relatch unit and action (actionQ picks the output)
            pulseD = pulseQ + 1'b1;
            if (pulseDone) begin
               stateD = bwdt_pkg::BWDT_IDLE;
               pulseD = '0;
            end
         end
         default: begin
            stateD = bwdt_pkg::BWDT_IDLE;
            countD = bwdt_pkg::COUNT_ZERO;
            pulseD = '0;
         end
      endcase
   end

   wire firing = (stateD == bwdt_pkg::BWDT_FIRE);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateQ <= bwdt_pkg::BWDT_IDLE;
         countQ <= bwdt_pkg::COUNT_ZERO;
         pulseQ <= '0;
         unitQ <= bwdt_pkg::UNIT_SECONDS;
         actionQ <= bwdt_pkg::ACTION_RESET;
      end else begin
         stateQ <= stateD;
         countQ <= countD;
         pulseQ <= pulseD;
         if (loadReq.load) begin
            unitQ <= unitMinutes; // R5
            actionQ <= actionNmi;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sysResetReq <= 1'b0;
         nmiReq <= 1'b0;
         running <= 1'b0;
         countOut <= bwdt_pkg::COUNT_ZERO;
      end else begin
         sysResetReq <= firing && (actionQ == bwdt_pkg::ACTION_RESET); // R1
         nmiReq <= firing && (actionQ == bwdt_pkg::ACTION_NMI); // R1
         running <= (stateD == bwdt_pkg::BWDT_COUNT);
         countOut <= countD;
      end
   end
endmodule : bwdt_core

// ===== src/bwdt_pkg.sv
package bwdt_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int SEC_CYCLES = CLK_HZ;
   localparam int MIN_SECONDS = 60;
   localparam int COUNT_W = 8;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;
   localparam int PRESCALE_W = 27;
   localparam int SECOND_W = 6;

   // Expiry actions
   localparam logic ACTION_RESET = 1'b0;
   localparam logic ACTION_NMI = 1'b1;
   // Unit select
   localparam logic UNIT_SECONDS = 1'b0;
   localparam logic UNIT_MINUTES = 1'b1;
   // Length of the reset or NMI pulse, in cycles
   localparam int PULSE_CYCLES = 16;
   localparam int PULSE_W = 5;

   typedef struct packed {
      logic load;
      logic [COUNT_W-1:0] value;
   } bwdt_load_t;

   typedef enum logic [2:0] {
      BWDT_IDLE = 3'b001,
      BWDT_COUNT = 3'b010,
      BWDT_FIRE = 3'b100
   } bwdt_state_t;
endpackage : bwdt_pkg

// ===== src/bwdt_timebase.sv
`timescale 1ns/100ps
// Produces one-cycle tick pulses in seconds or minutes. Restarts on clear
// so a reload always gets a full first unit.
module bwdt_timebase #(
   // Cycles per second; only a bench shortens it to reach expiry quickly
   parameter int SEC_CYCLES = bwdt_pkg::SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic unitMinutes,
   output logic tick
);
   logic [bwdt_pkg::PRESCALE_W-1:0] preQ;
   logic [bwdt_pkg::SECOND_W-1:0] secQ;
   wire secEnd = (preQ ==
      bwdt_pkg::PRESCALE_W'(SEC_CYCLES - 1));
   wire minEnd = (secQ ==
      bwdt_pkg::SECOND_W'(bwdt_pkg::MIN_SECONDS - 1));
   wire tickD = secEnd &&
      (unitMinutes == bwdt_pkg::UNIT_SECONDS || minEnd);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         preQ <= '0;
         secQ <= '0;
         tick <= 1'b0;
      end else if (clear) begin
         preQ <= '0;
         secQ <= '0;
         tick <= 1'b0;
      end else begin
         preQ <= secEnd ? '0 : preQ + 1'b1;
         if (secEnd) begin
            secQ <= minEnd ? '0 : secQ + 1'b1;
         end
         tick <= tickD;
      end
   end
endmodule : bwdt_timebase

// ===== bench/bwdt_core_asserts.sv
`timescale 1ns/100ps
module bwdt_core_asserts (
   input logic clk,
   input logic rst,
   input bwdt_pkg::bwdt_load_t loadReq,
   input logic unitMinutes,
   input logic actionNmi,
   input logic sysResetReq,
   input logic nmiReq,
   input logic running,
   input logic [bwdt_pkg::COUNT_W-1:0] countOut
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire quiet = !sysResetReq && !nmiReq;
   load_start_a: assert property (
      loadReq.load && loadReq.value != 0 && quiet
      |=> running && countOut == $past(loadReq.value)) else $error("no start");
   zero_stop_a: assert property (
      loadReq.load && loadReq.value == 0 && quiet
      |=> (!running && countOut == 0) [*3]) else $error("zero load ran");
   idle_zero_a: assert property (
      !running |-> countOut == 0) else $error("idle count set");
   one_action_a: assert property (
      !(sysResetReq && nmiReq)) else $error("both actions");
   fire_cause_a: assert property (
      $rose(sysResetReq) || $rose(nmiReq) |-> $past(running) && !running
      && $past(countOut) == 1) else $error("bad expiry");
   step_one_a: assert property (
      !$past(loadReq.load) && running && $changed(countOut)
      |-> countOut == $past(countOut) - 1) else $error("bad step");
endmodule : bwdt_core_asserts
bind bwdt_core bwdt_core_asserts bwdt_core_asserts_inst (.*);

// ===== bench/bwdt_host.sv
`timescale 1ns/100ps
// Host software side: each call is one firmware period-set service
module bwdt_host (
   input logic clk,
   output bwdt_pkg::bwdt_load_t loadReq
);
   initial loadReq = '0;
   task service(input logic [7:0] v);
      @(posedge clk) loadReq <= '{load: 1'b1, value: v};
      @(posedge clk) loadReq <= '{load: 1'b0, value: ~v};
   endtask : service
endmodule : bwdt_host

// ===== bench/bwdt_core_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
   error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module bwdt_core_bench;
   // Short second so that expiry is reached within the run
   localparam int TB_SEC = 20;
   localparam int TB_MIN = 60 * TB_SEC;
   logic clk, rst, unitMinutes, actionNmi, sysResetReq, nmiReq, running;
   logic [bwdt_pkg::COUNT_W-1:0] countOut;
   bwdt_pkg::bwdt_load_t loadReq;
   int error_cnt = 0;
   int n_compared = 0;
   bwdt_host bwdt_host_inst (.clk(clk), .loadReq(loadReq));
   bwdt_core #(.SEC_CYCLES(TB_SEC)) bwdt_core_inst (.clk(clk), .rst(rst),
      .loadReq(loadReq),
      .unitMinutes(unitMinutes), .actionNmi(actionNmi),
      .sysResetReq(sysResetReq), .nmiReq(nmiReq), .running(running),
      .countOut(countOut));
   task test_done;
      if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   task expect_state(input logic r, input logic [7:0] c);
      #1;
      `CHK("running", r, running)
      `CHK("countOut", c, countOut)
      `CHK("sysResetReq", 1'b0, sysResetReq)
      `CHK("nmiReq", 1'b0, nmiReq)
   endtask : expect_state
   task test_start_refresh;
      @(posedge clk) unitMinutes <= 1'b1;
      actionNmi <= 1'b1;
      bwdt_host_inst.service(8'hff);
      expect_state(1'b1, 8'hff);
      bwdt_host_inst.service(8'h01);
      expect_state(1'b1, 8'h01);
   endtask : test_start_refresh
   task test_disable;
      bwdt_host_inst.service(8'h00);
      expect_state(1'b0, 8'h00);
      repeat (40) @(posedge clk);
      expect_state(1'b0, 8'h00);
      bwdt_host_inst.service(8'h00);
      expect_state(1'b0, 8'h00);
   endtask : test_disable
   task test_reset_action;
      @(posedge clk) unitMinutes <= 1'b0;
      actionNmi <= 1'b0;
      bwdt_host_inst.service(8'h80);
      expect_state(1'b1, 8'h80);
   endtask : test_reset_action
   task wait_expiry(input int cyc, input logic nmi);
      repeat (cyc) @(posedge clk);
      expect_state(1'b1, 8'h01);
      @(posedge clk);
      #1;
      `CHK("sysResetReq", !nmi, sysResetReq)
      `CHK("nmiReq", nmi, nmiReq)
      `CHK("running", 1'b0, running)
      `CHK("countOut", 8'h00, countOut)
      repeat (15) @(posedge clk);
      #1;
      `CHK("sysResetReq", !nmi, sysResetReq)
      `CHK("nmiReq", nmi, nmiReq)
      @(posedge clk);
      #1;
      `CHK("sysResetReq", 1'b0, sysResetReq)
      `CHK("nmiReq", 1'b0, nmiReq)
   endtask : wait_expiry
   task test_expire_reset;
      @(posedge clk) unitMinutes <= 1'b0;
      actionNmi <= 1'b0;
      bwdt_host_inst.service(8'h03);
      wait_expiry(3 * TB_SEC, 1'b0);
   endtask : test_expire_reset
   task test_refresh_nmi;
      @(posedge clk) unitMinutes <= 1'b1;
      actionNmi <= 1'b1;
      bwdt_host_inst.service(8'h02);
      repeat (TB_MIN * 17 / 10) @(posedge clk);
      bwdt_host_inst.service(8'h02);
      expect_state(1'b1, 8'h02);
      wait_expiry(2 * TB_MIN, 1'b1);
   endtask : test_refresh_nmi
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      error_cnt++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      unitMinutes = 1'b0;
      actionNmi = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      expect_state(1'b0, 8'h00);
      test_start_refresh();
      test_disable();
      test_reset_action();
      test_disable();
      test_expire_reset();
      test_refresh_nmi();
      test_disable();
      test_done();
   end
endmodule : bwdt_core_bench
